/* fcs_floppy_cmd.sv */
// fcs_floppy_cmd: host register file and command interpreter of a floppy
// controller, with head positioning for seek and recalibrate.
// assumes drive inputs synchronous to clk and a classic wishbone master.
//
// Function
// - recalibrate: opcode, drive byte; step to track 0, then interrupt.
// - sense interrupt returns status zero then present cylinder; 80H alone when no interrupt pending.
// - seek: opcode, head/drive byte, new cylinder; head moves there.
// - register dump returns ten bytes of internal state.
// - unknown opcode is a no-op; one result byte 80H.
// - sense drive status: opcode, head/drive byte; returns status three.
// - eight host offsets; fifo at 5; 7 reads as zero, config write.
// - status A bit 7 shows the interrupt output in both modes.
// - first mode bit 6: 0 second drive present, 1 absent.
// - first mode bit 5: inverted active-low step output.
// - first mode bit 4: raw active-low track zero input.
// - first mode bit 3: inverted active-low head output.
// - first mode bit 2: raw active-low index input.
// - first mode bit 1: 0 protected, 1 writable.
// - bit 0 step direction; first mode 1 inward, second reversed.
// - second mode bit 6: dma request pin level.
// - second mode bit 5: inverted latched copy of step output.
// - second mode bit 4: inverted track zero input.
// - second mode bit 3: raw active-low head output.
// - second mode bit 2: inverted index input.
// - second mode bit 1: 0 writable, 1 protected.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module fcs_floppy_cmd
  import fcs_pkg::*;
#(
  parameter int unsigned STEP_UNIT_CYCLES = STEP_UNIT_DEF_CYCLES
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [5:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire fcs_drive_in_type driveIn, // drive and dma inputs
  output fcs_drive_out_type driveOut, // drive outputs
  output logic intOut // interrupt level
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic fcs_cmd_type decodeCmd(input logic [7:0] b);
    fcs_cmd_type k;
    k = CMD_INVALID;
    if (b[4:0] == OPC_FORMAT_LOW && !b[7] && !b[5]) k = CMD_FORMAT;
    else if (b == OPC_RECAL) k = CMD_RECAL;
    else if (b == OPC_SENSE_INT) k = CMD_SENSE_INT;
    else if (b == OPC_SPECIFY) k = CMD_SPECIFY;
    else if (b == OPC_SEEK) k = CMD_SEEK;
    else if (b == OPC_CONFIGURE) k = CMD_CONFIGURE;
    else if (b[7] && b[5:0] == OPC_RELSEEK_LOW) k = CMD_RELSEEK;
    else if (b == OPC_DUMP) k = CMD_DUMP;
    else if (b == OPC_PERP) k = CMD_PERP;
    else if (b[6:0] == OPC_LOCK_LOW) k = CMD_LOCK;
    else if (b == OPC_SENSE_DRV) k = CMD_SENSE_DRV;
    return k;
  endfunction

  function automatic logic [10:0] paramCount(input fcs_cmd_type k);
    logic [10:0] n;
    case (k)
      CMD_FORMAT: n = FORMAT_FIXED_PARAMS;
      CMD_RECAL, CMD_PERP, CMD_SENSE_DRV: n = 11'd1;
      CMD_SPECIFY, CMD_SEEK, CMD_RELSEEK: n = 11'd2;
      CMD_CONFIGURE: n = 11'd3;
      default: n = 11'd0;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  fcs_state_type state_q;
  fcs_cmd_type cmd_q;
  logic ackQ, intQ, stepFire_q, stepLatch_q, secondMode;
  logic [31:0] datQ;
  logic [7:0] opc_q, srtHut_q, hltNd_q, scEot_q, perp_q, cfg_q, precomp_start_track_q;
  logic [7:0] outCtrl_q, tape_q, rate_q, rateCfg_q, mode_q;
  logic [7:0] seekSt0_q, target_q, stepsLeft_q, rdByte, statusA, mainStat;
  logic [7:0] par_q [PAR_DEPTH];
  logic [7:0] res_q [RES_DEPTH];
  logic [7:0] pcn_q [4];
  logic [10:0] parCnt_q, parNeed_q;
  logic [3:0] resCnt_q, resIdx_q;
  logic [1:0] drv_q;
  logic head_q, dirInward_q, lock_q;
  logic [23:0] stepTimer_q, stepGap;
  logic [7:0] pulseCnt_q;
  logic busReq, wrEn, rdEn, fifoWr, fifoRd, saRead, engineRun;
  logic [3:0] regIdx;

  // ----------------------------------------------------------------------
  // wishbone slave: one wait state, ack for every address
  // ----------------------------------------------------------------------
  assign busReq = wb_cyc_i & wb_stb_i & ~ackQ;
  assign wrEn = busReq & wb_we_i & wb_sel_i[0];
  assign rdEn = busReq & ~wb_we_i;
  assign regIdx = wb_adr_i[5:2];
  assign fifoWr = wrEn && regIdx == REG_FIFO;
  assign fifoRd = rdEn && regIdx == REG_FIFO;
  assign saRead = rdEn && regIdx == REG_STATUS_A;
  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;
  assign secondMode = mode_q[MODE_SECOND_BIT];
  assign engineRun = outCtrl_q[OUT_CTRL_RUN_BIT];
  assign intOut = intQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= busReq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      datQ <= 32'h0;
    end else if (rdEn) begin
      datQ <= {24'h0, rdByte};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outCtrl_q <= OUT_CTRL_RESET;
      tape_q <= 8'h00;
      rate_q <= 8'h00;
      rateCfg_q <= 8'h00;
      mode_q <= 8'h00;
    end else if (wrEn) begin
      case (regIdx)
        REG_OUT_CTRL: outCtrl_q <= wb_dat_i[7:0];
        REG_TAPE: tape_q <= wb_dat_i[7:0];
        REG_MAIN_RATE: rate_q <= wb_dat_i[7:0];
        REG_INPUT_CC: rateCfg_q <= wb_dat_i[7:0];
        REG_MODE: mode_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // status A in both modes
  // ----------------------------------------------------------------------
  always_comb begin
    if (!secondMode) begin
      statusA = {intQ,
                 driveIn.secondDriveAbsent,
                 ~driveOut.stepN,
                 driveIn.trackZeroN,
                 ~driveOut.headN,
                 driveIn.indexN,
                 driveIn.writeProtN,
                 dirInward_q};
    end else begin
      statusA = {intQ,
                 driveIn.dmaRequest,
                 stepLatch_q,
                 ~driveIn.trackZeroN,
                 driveOut.headN,
                 ~driveIn.indexN,
                 ~driveIn.writeProtN,
                 ~dirInward_q};
    end
  end

  always_comb begin
    mainStat = 8'h00;
    mainStat[7] = state_q != ST_EXEC;
    mainStat[6] = state_q == ST_RESULT;
    mainStat[4] = state_q != ST_IDLE;
    if (state_q == ST_EXEC) mainStat[drv_q] = 1'b1;
  end

  always_comb begin
    case (regIdx)
      REG_STATUS_A: rdByte = statusA;
      REG_TAPE: rdByte = tape_q;
      REG_MAIN_RATE: rdByte = mainStat;
      REG_FIFO: rdByte = state_q == ST_RESULT ? res_q[resIdx_q] : 8'h00;
      REG_MODE: rdByte = mode_q;
      default: rdByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // step pulse and latched step copy
  // ----------------------------------------------------------------------
  assign stepGap = 24'(STEP_UNIT_CYCLES *
                       (STEP_RATE_SPAN - 32'(srtHut_q[7:4])));
  assign driveOut.stepN = pulseCnt_q == 8'h00;
  assign driveOut.dirInward = dirInward_q;
  assign driveOut.headN = ~head_q;
  assign driveOut.driveSel = drv_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pulseCnt_q <= 8'h00;
    end else if (stepFire_q) begin
      pulseCnt_q <= 8'(STEP_PULSE_CYCLES);
    end else if (pulseCnt_q != 8'h00) begin
      pulseCnt_q <= pulseCnt_q - 8'h01;
    end
  end

  // a step that lands in the read cycle stays latched for the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      stepLatch_q <= 1'b0;
    end else if (stepFire_q) begin
      stepLatch_q <= 1'b1;
    end else if (saRead) begin
      stepLatch_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      srtHut_q <= 8'h00;
      hltNd_q <= 8'h00;
      scEot_q <= 8'h00;
      perp_q <= 8'h00;
      cfg_q <= 8'h00;
      precomp_start_track_q <= 8'h00;
      lock_q <= 1'b0;
      for (int i = 0; i < 4; i++) pcn_q[i] <= 8'h00;
    end
    if (rst || !engineRun) begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_INVALID;
      opc_q <= 8'h00;
      intQ <= 1'b0;
      seekSt0_q <= 8'h00;
      parCnt_q <= 11'd0;
      parNeed_q <= 11'd0;
      resCnt_q <= 4'd0;
      resIdx_q <= 4'd0;
      drv_q <= 2'b00;
      head_q <= 1'b0;
      dirInward_q <= 1'b0;
      target_q <= 8'h00;
      stepsLeft_q <= 8'h00;
      stepTimer_q <= 24'h0;
      stepFire_q <= 1'b0;
      for (int i = 0; i < PAR_DEPTH; i++) par_q[i] <= 8'h00;
      for (int i = 0; i < RES_DEPTH; i++) res_q[i] <= 8'h00;
    end else begin
      stepFire_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (fifoWr) begin
            opc_q <= wb_dat_i[7:0];
            cmd_q <= decodeCmd(wb_dat_i[7:0]);
            parNeed_q <= paramCount(decodeCmd(wb_dat_i[7:0]));
            parCnt_q <= 11'd0;
            state_q <= ST_PARAM;
          end
        end
        ST_PARAM: begin
          if (parCnt_q == parNeed_q) begin
            resIdx_q <= 4'd0;
            case (cmd_q)
              CMD_FORMAT: begin
                scEot_q <= par_q[2];
                res_q[0] <= {5'b0, par_q[0][2:0]};
                for (int i = 1; i < 7; i++) res_q[i] <= 8'h00;
                resCnt_q <= FORMAT_RESULTS;
                state_q <= ST_RESULT;
              end
              CMD_RECAL: begin
                drv_q <= par_q[0][1:0];
                stepsLeft_q <= RECAL_MAX_STEPS;
                stepTimer_q <= 24'h0;
                state_q <= ST_EXEC;
              end
              CMD_SENSE_INT: begin
                if (intQ) begin
                  res_q[0] <= seekSt0_q;
                  res_q[1] <= pcn_q[seekSt0_q[1:0]];
                  resCnt_q <= 4'd2;
                  intQ <= 1'b0;
                end else begin
                  res_q[0] <= ST0_INVALID;
                  resCnt_q <= 4'd1;
                end
                state_q <= ST_RESULT;
              end
              CMD_SPECIFY: begin
                srtHut_q <= par_q[0];
                hltNd_q <= par_q[1];
                state_q <= ST_IDLE;
              end
              CMD_SEEK, CMD_RELSEEK: begin
                drv_q <= par_q[0][1:0];
                head_q <= par_q[0][2];
                target_q <= par_q[1];
                stepsLeft_q <= par_q[1];
                dirInward_q <= opc_q[OPC_DIR_BIT];
                stepTimer_q <= 24'h0;
                state_q <= ST_EXEC;
              end
              CMD_CONFIGURE: begin
                cfg_q <= par_q[1];
                precomp_start_track_q <= par_q[2];
                state_q <= ST_IDLE;
              end
              CMD_DUMP: begin
                for (int i = 0; i < 4; i++) res_q[i] <= pcn_q[i];
                res_q[4] <= srtHut_q;
                res_q[5] <= hltNd_q;
                res_q[6] <= scEot_q;
                res_q[7] <= {lock_q, 1'b0, perp_q[5:0]};
                res_q[8] <= {1'b0, cfg_q[6:0]};
                res_q[9] <= precomp_start_track_q;
                resCnt_q <= DUMP_RESULTS;
                state_q <= ST_RESULT;
              end
              CMD_PERP: begin
                perp_q <= par_q[0];
                state_q <= ST_IDLE;
              end
              CMD_LOCK: begin
                lock_q <= opc_q[OPC_LOCK_BIT];
                res_q[0] <= {3'b0, opc_q[OPC_LOCK_BIT], 4'b0};
                resCnt_q <= 4'd1;
                state_q <= ST_RESULT;
              end
              CMD_SENSE_DRV: begin
                res_q[0] <= {1'b0, ~driveIn.writeProtN, 1'b1,
                             ~driveIn.trackZeroN, 1'b0, par_q[0][2:0]};
                resCnt_q <= 4'd1;
                state_q <= ST_RESULT;
              end
              default: begin
                res_q[0] <= ST0_INVALID;
                resCnt_q <= 4'd1;
                state_q <= ST_RESULT;
              end
            endcase
          end else if (fifoWr) begin
            if (parCnt_q < 11'(PAR_DEPTH)) begin
              par_q[parCnt_q[2:0]] <= wb_dat_i[7:0];
            end
            // sector id bytes are counted, not kept
            if (cmd_q == CMD_FORMAT && parCnt_q == FORMAT_SC_INDEX) begin
              parNeed_q <= FORMAT_FIXED_PARAMS +
                           {1'b0, wb_dat_i[7:0], 2'b00};
            end
            parCnt_q <= parCnt_q + 11'd1;
          end
        end
        ST_EXEC: begin
          // direction is set one cycle before the step pulse starts; drives tolerate this here
          if (stepTimer_q != 24'h0) begin
            stepTimer_q <= stepTimer_q - 24'h1;
          end else begin
            case (cmd_q)
              CMD_RECAL: begin
                if (!driveIn.trackZeroN) begin
                  pcn_q[drv_q] <= 8'h00;
                  seekSt0_q <= ST0_SEEK_END | {6'b0, drv_q};
                  intQ <= 1'b1;
                  state_q <= ST_IDLE;
                end else if (stepsLeft_q == 8'h00) begin
                  seekSt0_q <= ST0_ABNORMAL | ST0_SEEK_END | ST0_EQUIP |
                               {6'b0, drv_q};
                  intQ <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  dirInward_q <= 1'b0;
                  stepFire_q <= 1'b1;
                  stepsLeft_q <= stepsLeft_q - 8'h01;
                  stepTimer_q <= stepGap;
                end
              end
              CMD_SEEK: begin
                if (pcn_q[drv_q] == target_q) begin
                  seekSt0_q <= ST0_SEEK_END | {5'b0, head_q, drv_q};
                  intQ <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  dirInward_q <= target_q > pcn_q[drv_q];
                  pcn_q[drv_q] <= target_q > pcn_q[drv_q] ?
                    pcn_q[drv_q] + 8'h01 : pcn_q[drv_q] - 8'h01;
                  stepFire_q <= 1'b1;
                  stepTimer_q <= stepGap;
                end
              end
              default: begin
                // relative seek stops early at track zero going outward
                if (stepsLeft_q == 8'h00 ||
                    (!dirInward_q && !driveIn.trackZeroN)) begin
                  seekSt0_q <= ST0_SEEK_END | {5'b0, head_q, drv_q};
                  intQ <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  pcn_q[drv_q] <= dirInward_q ?
                    pcn_q[drv_q] + 8'h01 : pcn_q[drv_q] - 8'h01;
                  stepsLeft_q <= stepsLeft_q - 8'h01;
                  stepFire_q <= 1'b1;
                  stepTimer_q <= stepGap;
                end
              end
            endcase
          end
        end
        ST_RESULT: begin
          if (fifoRd) begin
            if (resIdx_q + 4'd1 == resCnt_q) begin
              resIdx_q <= 4'd0;
              state_q <= ST_IDLE;
            end else begin
              resIdx_q <= resIdx_q + 4'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* fcs_pkg.sv */
// fcs_pkg: constants, types and register map of the floppy command block.
// assumes a 100 MHz core clock and a classic wishbone register bus.
package fcs_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned STEP_PULSE_NS = 1000;
  localparam int unsigned STEP_PULSE_CYCLES =
    (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STEP_UNIT_US = 1000;
  localparam int unsigned STEP_UNIT_DEF_CYCLES = STEP_UNIT_US * CLK_MHZ;
  localparam int unsigned STEP_RATE_SPAN = 16;

  // ----------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_STATUS_A = 4'h0;
  localparam logic [3:0] REG_STATUS_B = 4'h1;
  localparam logic [3:0] REG_OUT_CTRL = 4'h2;
  localparam logic [3:0] REG_TAPE = 4'h3;
  localparam logic [3:0] REG_MAIN_RATE = 4'h4;
  localparam logic [3:0] REG_FIFO = 4'h5;
  localparam logic [3:0] REG_INPUT_CC = 4'h7;
  localparam logic [3:0] REG_MODE = 4'h8;

  localparam logic [7:0] OUT_CTRL_RESET = 8'h04;
  localparam int unsigned OUT_CTRL_RUN_BIT = 2;
  localparam int unsigned MODE_SECOND_BIT = 0;

  // ----------------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------------
  localparam logic [4:0] OPC_FORMAT_LOW = 5'h0D;
  localparam logic [7:0] OPC_RECAL = 8'h07;
  localparam logic [7:0] OPC_SENSE_INT = 8'h08;
  localparam logic [7:0] OPC_SPECIFY = 8'h03;
  localparam logic [7:0] OPC_SEEK = 8'h0F;
  localparam logic [7:0] OPC_CONFIGURE = 8'h13;
  localparam logic [5:0] OPC_RELSEEK_LOW = 6'h0F;
  localparam logic [7:0] OPC_DUMP = 8'h0E;
  localparam logic [7:0] OPC_PERP = 8'h12;
  localparam logic [6:0] OPC_LOCK_LOW = 7'h14;
  localparam logic [7:0] OPC_SENSE_DRV = 8'h04;
  localparam int unsigned OPC_DIR_BIT = 6;
  localparam int unsigned OPC_LOCK_BIT = 7;

  // ----------------------------------------------------------------------
  // status bytes and sizes
  // ----------------------------------------------------------------------
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] ST0_EQUIP = 8'h10;
  localparam logic [7:0] RECAL_MAX_STEPS = 8'd79;
  localparam int unsigned PAR_DEPTH = 5;
  localparam int unsigned RES_DEPTH = 10;
  localparam logic [10:0] FORMAT_FIXED_PARAMS = 11'd5;
  localparam logic [10:0] FORMAT_SC_INDEX = 11'd2;
  localparam logic [3:0] FORMAT_RESULTS = 4'd7;
  localparam logic [3:0] DUMP_RESULTS = 4'd10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PARAM = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_RESULT = 4'b1000
  } fcs_state_type;

  typedef enum logic [3:0] {
    CMD_FORMAT, CMD_RECAL, CMD_SENSE_INT, CMD_SPECIFY, CMD_SEEK,
    CMD_CONFIGURE, CMD_RELSEEK, CMD_DUMP, CMD_PERP, CMD_LOCK,
    CMD_SENSE_DRV, CMD_INVALID
  } fcs_cmd_type;

  typedef struct packed {
    logic indexN;
    logic trackZeroN;
    logic writeProtN;
    logic secondDriveAbsent;
    logic dmaRequest;
  } fcs_drive_in_type;

  typedef struct packed {
    logic stepN;
    logic dirInward;
    logic headN;
    logic [1:0] driveSel;
  } fcs_drive_out_type;

endpackage

/* fcs_floppy_cmd_asserts.sv */
// fcs_floppy_cmd_asserts: bus and status checks on the command block.
// assumes one clock domain and a classic wishbone master.
`timescale 1ns/10ps
module fcs_floppy_cmd_asserts
  import fcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // reset, high
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [5:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire fcs_drive_in_type driveIn, // drive inputs
  input wire fcs_drive_out_type driveOut, // drive outputs
  input wire logic intOut // interrupt
);
  logic modeQ;
  logic take;
  fcs_drive_in_type pI;
  fcs_drive_out_type pO;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // pins as seen at the edge that took the read, since data is registered
  always_ff @(posedge clk) begin
    pI <= driveIn;
    pO <= driveOut;
    if (rst)
      modeQ <= 1'b0;
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == REG_MODE)
      modeQ <= wb_dat_i[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rdA;
    wb_ack_o && !wb_we_i && wb_adr_i[5:2] == REG_STATUS_A;
  endsequence
  ack_answer_a: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  read_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  unmapped_read_a: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i[5:2] == 4'h6 || wb_adr_i[5:2] > REG_MODE) |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  int_bit_a: assert property (rdA |-> wb_dat_o[7] == $past(intOut))
    else $error("status A bit 7 differs from interrupt");
  first_mode_a: assert property (rdA ##0 !modeQ |-> wb_dat_o[6:0] ==
    {pI.secondDriveAbsent, ~pO.stepN, pI.trackZeroN, ~pO.headN,
    pI.indexN, pI.writeProtN, pO.dirInward})
    else $error("status A first layout wrong");
  second_mode_a: assert property (rdA ##0 modeQ |->
    {wb_dat_o[6], wb_dat_o[4:0]} == {pI.dmaRequest, ~pI.trackZeroN,
    pO.headN, ~pI.indexN, ~pI.writeProtN, ~pO.dirInward})
    else $error("status A second layout wrong");
  step_width_a: assert property ($fell(driveOut.stepN) |->
    ##99 !driveOut.stepN ##1 driveOut.stepN)
    else $error("step pulse not 100 cycles");
endmodule
bind fcs_floppy_cmd fcs_floppy_cmd_asserts fcs_floppy_cmd_asserts_inst (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .driveIn(driveIn), .driveOut(driveOut), .intOut(intOut));

/* fcs_drive_model.sv */
// fcs_drive_model: one floppy drive that counts head steps.
// assumes step and direction lines synchronous to clk.
`timescale 1ns/10ps
module fcs_drive_model
  import fcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // reset, high
  input wire fcs_drive_out_type driveOut, // lines from controller
  input wire logic [3:0] misc, // index, protect, second drive, dma
  output fcs_drive_in_type driveIn // lines to controller
);
  logic [7:0] cylQ;
  logic stepQ;
  // move on the trailing edge, so one long pulse is one step
  always_ff @(posedge clk) begin
    stepQ <= driveOut.stepN;
    if (rst)
      cylQ <= 8'h00;
    else if (driveOut.stepN && !stepQ && (driveOut.dirInward || cylQ != 0))
      cylQ <= driveOut.dirInward ? cylQ + 8'h01 : cylQ - 8'h01;
  end
  assign driveIn = {misc[3], cylQ != 8'h00, misc[2:0]};
endmodule

/* tb_floppy_command_status.sv */
// tb_floppy_command_status: self-checking bench of the command block.
// assumes fcs_drive_model as the drive and a 100 MHz clock.
`timescale 1ns/10ps
module tb_floppy_command_status
  import fcs_pkg::*;
();
  logic clk, rst, cyc, stb, we, ack, intOut;
  logic [5:0] adr;
  logic [31:0] dat, datO;
  logic [3:0] misc;
  logic [7:0] last;
  logic [15:0] e;
  logic [15:0] q[$];
  int failures = 0, samplesChecked = 0, cycles = 0;
  fcs_drive_in_type dIn;
  fcs_drive_out_type dOut;
  fcs_floppy_cmd #(.STEP_UNIT_CYCLES(20)) fcs_floppy_cmd_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .driveIn(dIn), .driveOut(dOut), .intOut(intOut));
  fcs_drive_model fcs_drive_model_inst (.clk(clk), .rst(rst),
    .driveOut(dOut), .misc(misc), .driveIn(dIn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("failures %0d checked %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [3:0] i, input logic w, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, i, 2'b00, 24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    last = datO[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] x,
    input logic [7:0] m);
    q.push_back({m, x & m});
    bus(i, 1'b0, 8'h00);
  endtask
  task automatic cmd(input logic [7:0] b[$]);
    foreach (b[k]) bus(REG_FIFO, 1'b1, b[k]);
  endtask
  // poll main status until results are pending, then read them in order
  task automatic res(input logic [7:0] x[$], input logic [15:0] m);
    int n;
    // while results are pending the engine is ready and busy
    for (n = 0; n < 20 && (n == 0 || !last[6]); n++)
      rd(REG_MAIN_RATE, 8'h90, 8'h90);
    foreach (x[k]) rd(REG_FIFO, x[k], {8{m[k]}});
  endtask
  task automatic waitInt();
    int n;
    for (n = 0; n < 3000 && intOut !== 1'b1; n++) @(posedge clk);
  endtask
  function automatic logic [7:0] sa(logic m, it, t0, hd, dr);
    return m ? {it, misc[0], 1'b0, ~t0, ~hd, ~misc[3], ~misc[2], ~dr}
      : {it, misc[1], 1'b0, t0, hd, misc[3], misc[2], dr};
  endfunction
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      check(datO[7:0] & e[15:8], e[7:0]);
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {rst, cyc, stb, we, adr, dat, misc} = {4'h8, 38'h0, 4'h6};
    void'($urandom(65931));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      misc <= 4'($urandom);
      bus(REG_MODE, 1'b1, 8'(k & 1));
      rd(REG_STATUS_A, sa(k[0], '0, '0, '0, '0), 8'hFF);
    end
    bus(REG_MODE, 1'b1, 8'h00);
    // engine run bit low drops pending results and returns to idle
    cmd({8'h0E});
    bus(REG_OUT_CTRL, 1'b1, 8'h00);
    bus(REG_OUT_CTRL, 1'b1, 8'h04);
    rd(REG_MAIN_RATE, 8'h80, 8'hFF);
    rd(REG_FIFO, 8'h00, 8'hFF);
    cmd({8'h03, 8'h8A, 8'h0B});
    cmd({8'h0F, 8'h04, 8'h03});
    waitInt();
    bus(REG_MODE, 1'b1, 8'h01);
    rd(REG_STATUS_A, sa('1, '1, '1, '1, '1) | 8'h20, 8'hFF);
    rd(REG_STATUS_A, sa('1, '1, '1, '1, '1), 8'hFF);
    bus(REG_MODE, 1'b1, 8'h00);
    rd(REG_STATUS_A, sa('0, '1, '1, '1, '1), 8'hFF);
    cmd({8'h08});
    res({8'h24, 8'h03}, 16'h3);
    rd(REG_STATUS_A, sa('0, '0, '1, '1, '1), 8'hFF);
    cmd({8'h07, 8'h00});
    waitInt();
    cmd({8'h08});
    res({8'h20, 8'h00}, 16'h3);
    cmd({8'h04, 8'h05});
    res({8'h35 | (misc[2] ? 8'h00 : 8'h40)}, 16'h1);
    cmd({8'h01});
    res({8'h80}, 16'h1);
    rd(REG_FIFO, 8'h00, 8'hFF);
    rd(4'h6, 8'h00, 8'hFF);
    cmd({8'h94});
    res({8'h10}, 16'h1);
    cmd({8'h13, 8'h00, 8'h57, 8'h09, 8'h12, 8'h0C, 8'h0E});
    res({8'h00, 8'h00, 8'h00, 8'h00, 8'h8A, 8'h0B, 8'h00, 8'h8C, 8'h57,
      8'h09}, 16'h3BF);
    cmd({8'h0D, 8'h00, 8'h02, 8'h01, 8'h1B, 8'hE5, 8'h00, 8'h00, 8'h01,
      8'h02});
    res({8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 16'h7);
    // relative seek inward by two on drive 1
    cmd({8'hCF, 8'h01, 8'h02});
    waitInt();
    cmd({8'h08});
    res({8'h21, 8'h02}, 16'h3);
    check({6'h0, dOut.driveSel}, 8'h01);
    final_report();
  end
endmodule
